// *** bench/fwe_flash_seq_sva.sv ***
// port checker for the flash write latch, erase and suspend sequencer
`timescale 1ns/1ns
module fwe_flash_seq_sva (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] status_bits,
	input wire logic [7:0] flag_bits,
	input wire logic erase_suspended,
	input wire logic cfg_write_ok,
	input wire logic erase_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_RESET_VALUES: assert property ($fell(sys_rst) |-> status_bits == 8'h00 && flag_bits == 8'h80)
		else $error("bad values after reset");
	AST_WIP_VS_READY: assert property (status_bits[0] != flag_bits[7])
		else $error("busy and ready disagree");
	AST_START_CLEARS_WEL: assert property ($rose(status_bits[0]) && $past(flag_bits[7]) && !$past(flag_bits[6])
		&& !$past(flag_bits[2]) |-> !status_bits[1])
		else $error("latch kept at start");
	AST_DONE_PULSE: assert property (erase_done |=> !erase_done)
		else $error("done longer than a cycle");
	AST_DONE_IDLE: assert property (erase_done |-> ##[0:1] (!status_bits[0] && flag_bits[7]))
		else $error("busy after done");
	AST_SUSP_LATENCY: assert property ($rose(flag_bits[6]) |-> ##[1:220] flag_bits[7])
		else $error("no ready after suspend");
	AST_SUSP_STATE: assert property ($rose(erase_suspended) |-> ##[0:1] (flag_bits[6] && flag_bits[7]))
		else $error("suspend flags wrong");
	AST_PROT_KEEPS_WEL: assert property ($rose(flag_bits[5]) && flag_bits[1] |-> status_bits[1] && !status_bits[0])
		else $error("protect error lost latch");
	AST_TIMEOUT_WEL: assert property ($rose(flag_bits[5]) && !flag_bits[1] |-> !status_bits[1] && !erase_done)
		else $error("timeout kept latch");
	AST_PROG_BLOCKED: assert property ($rose(flag_bits[4]) && $past(erase_suspended) && $past(flag_bits[7])
		|-> status_bits[1])
		else $error("blocked program changed latch");
	AST_CFG_IN_SUSP: assert property (erase_suspended && $past(erase_suspended) && flag_bits[7] |-> cfg_write_ok)
		else $error("config writes refused in suspend");
	AST_PROG_SUSP_LATENCY: assert property ($rose(flag_bits[2]) |-> ##[1:220] flag_bits[7])
		else $error("no ready after program suspend");
	cover property ($rose(erase_suspended));
	cover property (flag_bits[2] && flag_bits[6] && flag_bits[7]);
	cover property (erase_done);
	cover property ($rose(flag_bits[5]) && flag_bits[1]);
endmodule
bind fwe_flash_seq fwe_flash_seq_sva fwe_flash_seq_sva_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.status_bits(status_bits), .flag_bits(flag_bits), .erase_suspended(erase_suspended),
	.cfg_write_ok(cfg_write_ok), .erase_done(erase_done));

// *** bench/fwe_flash_seq_tb_top.sv ***
// self-checking bench for the flash write latch, erase and suspend sequencer
`timescale 1ns/1ns
module fwe_flash_seq_tb_top;
	import fwe_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst;
	logic sel_n_pin, serial_clk_pin, op_timeout_fault, erase_suspended, cfg_write_ok, erase_done, seen;
	logic [3:0] dq_pin;
	logic [63:0] sector_protect;
	logic [7:0] status_bits, flag_bits;
	logic [5:0] suspended_sector;
	fwe_proto_t proto_mode;
	fwe_region_t erase_region;
	int err_total = 0;
	int comparisons = 0;
	always #50 core_clk = ~core_clk;
	fwe_host_model fwe_host_model_i (.sel_n_pin(sel_n_pin), .serial_clk_pin(serial_clk_pin), .dq_pin(dq_pin));
	fwe_flash_seq #(.SUBSECTOR_ERASE_TIME_US(30), .SECTOR_ERASE_TIME_US(40), .FULL_ARRAY_ERASE_TIME_US(50),
		.PROGRAM_TIME_US(30)) fwe_flash_seq_i (.core_clk(core_clk), .sys_rst(sys_rst), .sel_n_pin(sel_n_pin),
		.serial_clk_pin(serial_clk_pin), .dq_pin(dq_pin), .proto_mode(proto_mode), .sector_protect(sector_protect),
		.op_timeout_fault(op_timeout_fault), .status_bits(status_bits), .flag_bits(flag_bits),
		.erase_suspended(erase_suspended), .suspended_sector(suspended_sector), .cfg_write_ok(cfg_write_ok),
		.erase_done(erase_done), .erase_region(erase_region));
	task automatic print_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic regs(input logic [7:0] s, input logic [7:0] f);
		chk(status_bits, s, "status");
		chk(flag_bits, f, "flags");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		cyc(4);
		sys_rst = 1'b0;
		cyc(3);
	endtask
	task automatic frm(input logic [63:0] v, input int n);
		cyc(1);
		fwe_host_model_i.send(v, n, proto_mode == FWE_PROTO_QUAD ? 4 : proto_mode == FWE_PROTO_DUAL ? 2 : 1);
		cyc(2);
	endtask
	task automatic cmd(input logic [7:0] o);
		frm({o, 56'h0}, 8);
	endtask
	task automatic ers(input logic [7:0] o, input logic [23:0] a, input int n);
		frm({o, a, 32'h0}, n);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		seen = 1'b0;
		for (int k = 0; k < 1000 && n < 3; k++) begin
			cyc(1);
			if (erase_done === 1'b1) seen = 1'b1;
			if (flag_bits[7] === 1'b1) n++;
		end
		chk(n, 3, "wait for idle");
	endtask
	task automatic t_latch();
		for (int i = 0; i < 3; i++) begin
			proto_mode = fwe_proto_t'(i);
			cmd(OP_WRITE_ENABLE);
			regs(8'h02, 8'h80);
			cmd(OP_WRITE_DISABLE);
			regs(8'h00, 8'h80);
		end
		proto_mode = FWE_PROTO_EXT;
		frm({OP_WRITE_ENABLE, OP_WRITE_ENABLE, 48'h0}, 16);
		regs(8'h00, 8'h80);
		cmd(OP_WRITE_ENABLE);
		frm({OP_WRITE_DISABLE, 56'h0}, 9);
		regs(8'h02, 8'h80);
		cmd(OP_WRITE_DISABLE);
		ers(OP_SECTOR_ERASE, 24'h010000, 32);
		regs(8'h00, 8'h80);
	endtask
	task automatic t_erase();
		logic [7:0] op [3] = '{OP_SUBSECTOR_ERASE, OP_SECTOR_ERASE, OP_BULK_ERASE};
		int nb [3] = '{32, 32, 8};
		for (int i = 0; i < 3; i++) begin
			cmd(OP_WRITE_ENABLE);
			ers(op[i], 24'h03A5C0, nb[i]);
			regs(8'h01, 8'h00);
			chk(erase_region.kind, i, "kind");
			if (i < 2) chk(erase_region.addr, 24'h03A5C0, "addr");
			wait_idle();
			chk(seen, 1'b1, "done");
			regs(8'h00, 8'h80);
		end
	endtask
	task automatic t_faults();
		cmd(OP_WRITE_ENABLE);
		ers(OP_SECTOR_ERASE, 24'h030000, 40);
		regs(8'h02, 8'h80);
		sector_protect = 64'h8;
		ers(OP_SECTOR_ERASE, 24'h031234, 32);
		regs(8'h02, 8'hA2);
		cmd(OP_CLEAR_FLAGS);
		cmd(OP_BULK_ERASE);
		regs(8'h02, 8'hA2);
		cmd(OP_CLEAR_FLAGS);
		sector_protect = 64'h0;
		ers(OP_SUBSECTOR_ERASE, 24'h001000, 32);
		op_timeout_fault = 1'b1;
		wait_idle();
		chk(seen, 1'b0, "done on timeout");
		regs(8'h00, 8'hA0);
		op_timeout_fault = 1'b0;
		cmd(OP_CLEAR_FLAGS);
	endtask
	task automatic t_suspend();
		cmd(OP_WRITE_ENABLE);
		ers(OP_SECTOR_ERASE, 24'h050000, 32);
		cmd(OP_SUSPEND);
		regs(8'h01, 8'h40);
		cyc(220);
		regs(8'h00, 8'hC0);
		chk(erase_suspended, 1'b1, "suspended");
		chk(suspended_sector, 6'h05, "sector");
		chk(cfg_write_ok, 1'b1, "cfg ok");
		cmd(OP_WRITE_ENABLE);
		frm({OP_PAGE_PROGRAM, 24'h0500FF, 32'h5A000000}, 40);
		regs(8'h02, 8'hD0);
		frm({OP_PAGE_PROGRAM, 24'h0600FF, 32'h5A000000}, 40);
		regs(8'h01, 8'h50);
		cmd(OP_SUSPEND);
		regs(8'h01, 8'h54);
		cyc(220);
		regs(8'h00, 8'hD4);
		cmd(OP_RESUME);
		regs(8'h01, 8'h50);
		wait_idle();
		chk(seen, 1'b0, "nested done");
		regs(8'h00, 8'hD0);
		cmd(OP_WRITE_DISABLE);
		cmd(OP_RESUME);
		regs(8'h01, 8'h10);
		do_reset();
		regs(8'h00, 8'h80);
		chk(erase_suspended, 1'b0, "suspend lost");
		cmd(OP_RESUME);
		regs(8'h00, 8'h80);
		cmd(OP_WRITE_ENABLE);
		ers(OP_SUBSECTOR_ERASE, 24'h002000, 32);
		cyc(150);
		cmd(OP_SUSPEND);
		chk(flag_bits[6], 1'b1, "late suspend");
		wait_idle();
		chk(seen, 1'b1, "late done");
		regs(8'h00, 8'h80);
	endtask
	initial begin
		proto_mode = FWE_PROTO_EXT;
		sector_protect = 64'h0;
		op_timeout_fault = 1'b0;
		do_reset();
		regs(8'h00, 8'h80);
		t_latch();
		t_erase();
		t_faults();
		t_suspend();
		print_verdict();
	end
	initial begin
		#5000000;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
endmodule

// *** bench/fwe_host_model.sv ***
// host controller model driving command frames onto the serial pins
`timescale 1ns/1ns
module fwe_host_model (
	output logic sel_n_pin,
	output logic serial_clk_pin,
	output logic [3:0] dq_pin
);
	initial begin
		sel_n_pin = 1'b1;
		serial_clk_pin = 1'b0;
		dq_pin = 4'h5;
	end
	task automatic send(input logic [63:0] v, input int n, input int w);
		logic [3:0] m;
		m = 4'hF >> (4 - w);
		sel_n_pin = 1'b0;
		for (int i = 0; i < n; i += w) begin
			#200 dq_pin = (v[63:60] >> (4 - w)) & m | ~dq_pin & ~m;
			v = v << w;
			#200 serial_clk_pin = 1'b1;
			#400 serial_clk_pin = 1'b0;
		end
		#200 sel_n_pin = 1'b1;
		dq_pin = ~dq_pin;
		#800;
	endtask
endmodule

// *** shared/fwe_pkg.sv ***
// constants, types and opcodes for the flash write-latch, erase and suspend sequencer
// Functional notes
// - write-enable 06h sets the latch; write-disable 04h clears it; opcode only.
// - write-enable not closed right after its opcode is dropped; latch stays 0.
// - write-disable not closed right after its opcode is dropped; latch stays 1.
// - subsector erase is opcode plus three address bytes; erases subsector on select rise.
// - sector erase is opcode plus three address bytes; erases whole sector on select rise.
// - bulk erase is opcode alone; erases whole array on select rise.
// - erase commands with the latch clear are ignored and set no error bit.
// - write-in-progress is 1 during erase, 0 after; latch cleared either way.
// - erase timeout resets the latch and sets the erase error bit.
// - erase not closed at the proper bit is dropped; no flags; latch stays 1.
// - erase of protected region does nothing; latch stays 1; flag bits 1 and 5 set.
// - bulk erase with any sector locked does nothing; latch stays; bits 1 and 5 set.
// - suspend is one opcode; state holds until resume; suspends program or erase.
// - suspend during program sets flag bit 2 at once, bit 7 after latency.
// - suspend during erase sets flag bit 6 at once, bit 7 after latency.
// - if remaining time is under the latency, finish and clear bit 2 or 6.
// - suspend state is volatile; flag status register comes up as 80h.
// - in erase suspend, program and read allowed outside the suspended sector.
// - program into the erase-suspended sector is ignored, sets flag bit 4, latch unchanged.
// - in erase suspend, lock and volatile configuration writes are accepted.
// - resume sets write-in-progress, clears controller-ready bit; ignored when not suspended.
// - one nesting level: program inside erase suspend; resumes undo in reverse order.
package fwe_pkg;

	localparam int unsigned CLK_MHZ = 10;

	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
	localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;

	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
	localparam logic [5:0] PROG_MIN_BITS = 6'h28;
	localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;

	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_MSB = 21;

	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	localparam int FSR_PROT_ERR = 1;
	localparam int FSR_PROG_SUSP = 2;
	localparam int FSR_PROG_ERR = 4;
	localparam int FSR_ERASE_ERR = 5;
	localparam int FSR_ERASE_SUSP = 6;
	localparam int FSR_READY = 7;

	localparam logic [7:0] FSR_RESET = 8'h80;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [5:0] PIN_SYNC_RESET = 6'h20;

	localparam int unsigned SUBSECTOR_ERASE_TIME_US = 50000;
	localparam int unsigned SECTOR_ERASE_TIME_US = 150000;
	localparam int unsigned FULL_ARRAY_ERASE_TIME_US = 10000000;
	localparam int unsigned PROGRAM_TIME_US = 500;
	localparam int unsigned SUSPEND_LATENCY_US = 20;
	localparam logic [31:0] SUSPEND_LATENCY_CYCLES = 32'(SUSPEND_LATENCY_US * CLK_MHZ);

	typedef enum logic [1:0] {
		FWE_PROTO_EXT = 2'h0,
		FWE_PROTO_DUAL = 2'h1,
		FWE_PROTO_QUAD = 2'h2
	} fwe_proto_t;

	typedef enum logic [1:0] {
		FWE_ERASE_SUB = 2'h0,
		FWE_ERASE_SECTOR = 2'h1,
		FWE_ERASE_BULK = 2'h2
	} fwe_erase_kind_t;

	typedef enum logic [2:0] {
		FWE_ST_IDLE = 3'b000,
		FWE_ST_ERASE = 3'b001,
		FWE_ST_PROG = 3'b010,
		FWE_ST_ERASE_SUSP = 3'b011,
		FWE_ST_PROG_IN_SUSP = 3'b100,
		FWE_ST_PROG_SUSP = 3'b101,
		FWE_ST_BOTH_SUSP = 3'b110
	} fwe_state_t;

	typedef struct packed {
		logic done;
		logic [5:0] nbits;
		logic [7:0] opcode;
		logic [23:0] addr;
	} fwe_frame_t;

	typedef struct packed {
		fwe_erase_kind_t kind;
		logic [23:0] addr;
	} fwe_region_t;

endpackage

// *** src/fwe_flash_seq.sv ***
// write enable latch, erase and program/erase suspend sequencer
`timescale 1ns/1ns
module fwe_flash_seq #(
	parameter int unsigned SUBSECTOR_ERASE_TIME_US = fwe_pkg::SUBSECTOR_ERASE_TIME_US,
	parameter int unsigned SECTOR_ERASE_TIME_US = fwe_pkg::SECTOR_ERASE_TIME_US,
	parameter int unsigned FULL_ARRAY_ERASE_TIME_US = fwe_pkg::FULL_ARRAY_ERASE_TIME_US,
	parameter int unsigned PROGRAM_TIME_US = fwe_pkg::PROGRAM_TIME_US
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sel_n_pin,
	input wire logic serial_clk_pin,
	input wire logic [3:0] dq_pin,
	input wire fwe_pkg::fwe_proto_t proto_mode,
	input wire logic [63:0] sector_protect,
	input wire logic op_timeout_fault,
	output logic [7:0] status_bits,
	output logic [7:0] flag_bits,
	output logic erase_suspended,
	output logic [5:0] suspended_sector,
	output logic cfg_write_ok,
	output logic erase_done,
	output fwe_pkg::fwe_region_t erase_region
);
	import fwe_pkg::*;

	localparam logic [31:0] SUBSECTOR_ERASE_CYCLES = 32'(SUBSECTOR_ERASE_TIME_US * CLK_MHZ);
	localparam logic [31:0] SECTOR_ERASE_CYCLES = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ);
	localparam logic [31:0] FULL_ARRAY_ERASE_CYCLES = 32'(FULL_ARRAY_ERASE_TIME_US * CLK_MHZ);
	localparam logic [31:0] PROGRAM_CYCLES = 32'(PROGRAM_TIME_US * CLK_MHZ);

	fwe_frame_t frame;
	fwe_state_t state;
	fwe_state_t next_state;
	fwe_region_t region;
	logic wel;
	logic next_wel;
	logic [31:0] erase_remain;
	logic [31:0] prog_remain;
	logic [31:0] lat_cnt;
	logic susp_pending;
	logic prog_susp_flag;
	logic erase_susp_flag;
	logic next_prog_susp_flag;
	logic next_erase_susp_flag;
	logic prot_err;
	logic prog_err;
	logic erase_err;
	logic next_prot_err;
	logic next_prog_err;
	logic next_erase_err;
	logic running;
	logic next_running;
	logic prog_active;
	logic [31:0] active_remain;
	logic [5:0] addr_sector;
	logic op_only;
	logic addr_only;
	logic prog_frame;
	logic ev_wren;
	logic ev_wrdi;
	logic ev_clear;
	logic erase_req;
	logic erase_prot;
	logic ev_erase_go;
	logic ev_erase_prot;
	logic ev_prog_go;
	logic ev_prog_block;
	logic ev_prog_prot;
	logic ev_suspend;
	logic ev_resume;
	logic ev_done;
	logic ev_taken;
	fwe_erase_kind_t req_kind;

	fwe_link_rx u_rx (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.sel_n_pin(sel_n_pin),
		.serial_clk_pin(serial_clk_pin),
		.dq_pin(dq_pin),
		.proto_mode(proto_mode),
		.frame(frame)
	);

	function automatic logic [31:0] erase_cycles(input fwe_erase_kind_t kind);
		case (kind)
			FWE_ERASE_SUB: erase_cycles = SUBSECTOR_ERASE_CYCLES;
			FWE_ERASE_SECTOR: erase_cycles = SECTOR_ERASE_CYCLES;
			default: erase_cycles = FULL_ARRAY_ERASE_CYCLES;
		endcase
	endfunction

	function automatic logic is_running(input fwe_state_t st);
		is_running = (st == FWE_ST_ERASE) || (st == FWE_ST_PROG) || (st == FWE_ST_PROG_IN_SUSP);
	endfunction

	function automatic logic in_erase_susp(input fwe_state_t st);
		in_erase_susp = (st == FWE_ST_ERASE_SUSP) || (st == FWE_ST_PROG_IN_SUSP) || (st == FWE_ST_BOTH_SUSP);
	endfunction

	// frame length checks: select must rise exactly at the right bit, or at a byte boundary from bit 40 to bit 56 for program
	assign op_only = frame.nbits == OPCODE_BITS;
	assign addr_only = frame.nbits == ADDR_CMD_BITS;
	assign prog_frame = (frame.nbits >= PROG_MIN_BITS) && (frame.nbits[2:0] == 3'h0);
	assign addr_sector = frame.addr[SECTOR_MSB:SECTOR_LSB];

	assign running = is_running(state);
	assign prog_active = (state == FWE_ST_PROG) || (state == FWE_ST_PROG_IN_SUSP);
	assign active_remain = prog_active ? prog_remain : erase_remain;

	assign ev_wren = frame.done && op_only && frame.opcode == OP_WRITE_ENABLE;
	assign ev_wrdi = frame.done && op_only && frame.opcode == OP_WRITE_DISABLE;
	assign ev_clear = frame.done && op_only && frame.opcode == OP_CLEAR_FLAGS;

	// subsector, sector and bulk erase decode
	always_comb begin
		req_kind = FWE_ERASE_BULK;
		erase_req = 1'b0;
		erase_prot = 1'b0;
		if (frame.opcode == OP_SUBSECTOR_ERASE || frame.opcode == OP_SECTOR_ERASE) begin
			req_kind = (frame.opcode == OP_SUBSECTOR_ERASE) ? FWE_ERASE_SUB : FWE_ERASE_SECTOR;
			erase_req = addr_only;
			erase_prot = sector_protect[addr_sector];
		end else if (frame.opcode == OP_BULK_ERASE) begin
			erase_req = op_only;
			erase_prot = |sector_protect;
		end
	end

	// latch clear means ignore without error
	assign ev_erase_go = frame.done && erase_req && wel && state == FWE_ST_IDLE && !erase_prot;
	assign ev_erase_prot = frame.done && erase_req && wel && state == FWE_ST_IDLE && erase_prot;

	// program allowed in erase suspend outside the suspended sector
	always_comb begin
		ev_prog_go = 1'b0;
		ev_prog_block = 1'b0;
		ev_prog_prot = 1'b0;
		if (frame.done && prog_frame && frame.opcode == OP_PAGE_PROGRAM && wel) begin
			if (state == FWE_ST_ERASE_SUSP &&
				(region.kind == FWE_ERASE_BULK || addr_sector == region.addr[SECTOR_MSB:SECTOR_LSB])) begin
				ev_prog_block = 1'b1;
			end else if (state == FWE_ST_IDLE || state == FWE_ST_ERASE_SUSP) begin
				ev_prog_prot = sector_protect[addr_sector];
				ev_prog_go = !sector_protect[addr_sector];
			end
		end
	end

	// suspend accepted only while an operation runs
	assign ev_suspend = frame.done && op_only && frame.opcode == OP_SUSPEND && running && !susp_pending &&
		!(prog_active ? prog_susp_flag : erase_susp_flag);
	assign ev_resume = frame.done && op_only && frame.opcode == OP_RESUME && !running &&
		(state == FWE_ST_ERASE_SUSP || state == FWE_ST_PROG_SUSP || state == FWE_ST_BOTH_SUSP);

	assign ev_done = running && active_remain == 32'h1;
	assign ev_taken = susp_pending && lat_cnt == 32'h1 && !ev_done;

	// operation state with one nesting level
	always_comb begin
		next_state = state;
		case (state)
			FWE_ST_IDLE: begin
				if (ev_erase_go) begin
					next_state = FWE_ST_ERASE;
				end else if (ev_prog_go) begin
					next_state = FWE_ST_PROG;
				end
			end
			FWE_ST_ERASE: begin
				if (ev_done) begin
					next_state = FWE_ST_IDLE;
				end else if (ev_taken) begin
					next_state = FWE_ST_ERASE_SUSP;
				end
			end
			FWE_ST_PROG: begin
				if (ev_done) begin
					next_state = FWE_ST_IDLE;
				end else if (ev_taken) begin
					next_state = FWE_ST_PROG_SUSP;
				end
			end
			FWE_ST_ERASE_SUSP: begin
				if (ev_prog_go) begin
					next_state = FWE_ST_PROG_IN_SUSP;
				end else if (ev_resume) begin
					next_state = FWE_ST_ERASE;
				end
			end
			FWE_ST_PROG_IN_SUSP: begin
				if (ev_done) begin
					next_state = FWE_ST_ERASE_SUSP;
				end else if (ev_taken) begin
					next_state = FWE_ST_BOTH_SUSP;
				end
			end
			FWE_ST_PROG_SUSP: begin
				if (ev_resume) begin
					next_state = FWE_ST_PROG;
				end
			end
			FWE_ST_BOTH_SUSP: begin
				if (ev_resume) begin
					next_state = FWE_ST_PROG_IN_SUSP;
				end
			end
			default: begin
				next_state = FWE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= FWE_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// write enable latch
	always_comb begin
		next_wel = wel;
		if (ev_wren) begin
			next_wel = 1'b1;
		end else if (ev_wrdi) begin
			next_wel = 1'b0;
		// latch cleared once an operation starts
		end else if (ev_erase_go || ev_prog_go) begin
			next_wel = 1'b0;
		end else if (ev_done && op_timeout_fault) begin
			next_wel = 1'b0;
		end
	end

	// reset value of the latch is 0
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wel <= 1'b0;
		end else begin
			wel <= next_wel;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			erase_remain <= 32'h0;
		end else if (ev_erase_go) begin
			erase_remain <= erase_cycles(req_kind);
		end else if (state == FWE_ST_ERASE && erase_remain != 32'h0) begin
			erase_remain <= erase_remain - 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prog_remain <= 32'h0;
		end else if (ev_prog_go) begin
			prog_remain <= PROGRAM_CYCLES;
		end else if (prog_active && prog_remain != 32'h0) begin
			prog_remain <= prog_remain - 32'h1;
		end
	end

	// suspend only pends if enough time remains
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			susp_pending <= 1'b0;
			lat_cnt <= 32'h0;
		end else if (ev_suspend && active_remain > SUSPEND_LATENCY_CYCLES) begin
			susp_pending <= 1'b1;
			lat_cnt <= SUSPEND_LATENCY_CYCLES;
		end else if (ev_done || ev_taken) begin
			susp_pending <= 1'b0;
			lat_cnt <= 32'h0;
		end else if (susp_pending) begin
			lat_cnt <= lat_cnt - 32'h1;
		end
	end

	// suspend indication bits
	always_comb begin
		next_prog_susp_flag = prog_susp_flag;
		next_erase_susp_flag = erase_susp_flag;
		if (ev_suspend) begin
			if (prog_active) begin
				next_prog_susp_flag = 1'b1;
			end else begin
				next_erase_susp_flag = 1'b1;
			end
		end
		if (ev_done) begin
			if (prog_active) begin
				next_prog_susp_flag = 1'b0;
			end else begin
				next_erase_susp_flag = 1'b0;
			end
		end
		if (ev_resume) begin
			if (state == FWE_ST_ERASE_SUSP) begin
				next_erase_susp_flag = 1'b0;
			end else begin
				next_prog_susp_flag = 1'b0;
			end
		end
	end

	// error bits: a new error wins over a clear
	always_comb begin
		next_prot_err = prot_err && !ev_clear;
		next_prog_err = prog_err && !ev_clear;
		next_erase_err = erase_err && !ev_clear;
		// protection fail sets bit 1 plus bit 5 for erase or bit 4 for program
		if (ev_erase_prot) begin
			next_prot_err = 1'b1;
			next_erase_err = 1'b1;
		end
		if (ev_prog_prot) begin
			next_prot_err = 1'b1;
			next_prog_err = 1'b1;
		end
		// suspended sector program sets bit 4
		if (ev_prog_block) begin
			next_prog_err = 1'b1;
		end
		if (ev_done && op_timeout_fault) begin
			if (prog_active) begin
				next_prog_err = 1'b1;
			end else begin
				next_erase_err = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prog_susp_flag <= 1'b0;
			erase_susp_flag <= 1'b0;
			prot_err <= 1'b0;
			prog_err <= 1'b0;
			erase_err <= 1'b0;
		end else begin
			prog_susp_flag <= next_prog_susp_flag;
			erase_susp_flag <= next_erase_susp_flag;
			prot_err <= next_prot_err;
			prog_err <= next_prog_err;
			erase_err <= next_erase_err;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			region <= '0;
		end else if (ev_erase_go) begin
			region.kind <= req_kind;
			region.addr <= frame.addr;
		end
	end

	assign next_running = is_running(next_state);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			status_bits <= SR_RESET;
			flag_bits <= FSR_RESET;
		end else begin
			status_bits <= SR_RESET;
			status_bits[SR_WIP] <= next_running;
			status_bits[SR_WEL] <= next_wel;
			flag_bits <= 8'h00;
			// ready bit shows the suspended state after latency
			flag_bits[FSR_READY] <= !next_running;
			flag_bits[FSR_ERASE_SUSP] <= next_erase_susp_flag;
			flag_bits[FSR_ERASE_ERR] <= next_erase_err;
			flag_bits[FSR_PROG_ERR] <= next_prog_err;
			flag_bits[FSR_PROG_SUSP] <= next_prog_susp_flag;
			flag_bits[FSR_PROT_ERR] <= next_prot_err;
		end
	end

	// completed erase reported with its region
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			erase_done <= 1'b0;
			erase_region <= '0;
		end else begin
			erase_done <= ev_done && !prog_active && !op_timeout_fault;
			erase_region <= region;
		end
	end

	// register writes allowed when idle or suspended
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_write_ok <= 1'b1;
			erase_suspended <= 1'b0;
			suspended_sector <= 6'h00;
		end else begin
			cfg_write_ok <= !next_running;
			erase_suspended <= in_erase_susp(next_state);
			suspended_sector <= region.addr[SECTOR_MSB:SECTOR_LSB];
		end
	end

endmodule

// *** src/fwe_link_rx.sv ***
// serial command receiver: pin synchronisers, edge detection and frame capture
`timescale 1ns/1ns
module fwe_link_rx (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sel_n_pin,
	input wire logic serial_clk_pin,
	input wire logic [3:0] dq_pin,
	input wire fwe_pkg::fwe_proto_t proto_mode,
	output fwe_pkg::fwe_frame_t frame
);
	import fwe_pkg::*;

	logic [5:0] pin_raw;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic clk_hist;
	logic sel_hist;
	logic clk_rise;
	logic sel_rise;
	logic [5:0] bit_cnt;
	logic [5:0] next_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] opcode;
	logic [23:0] addr;

	assign pin_raw = {sel_n_pin, serial_clk_pin, dq_pin};

	// two-flop synchroniser per pin
	for (genvar i = 0; i < 6; i++) begin : g_sync
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				pin_meta[i] <= PIN_SYNC_RESET[i];
				pin_sync[i] <= PIN_SYNC_RESET[i];
			end else begin
				pin_meta[i] <= pin_raw[i];
				pin_sync[i] <= pin_meta[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clk_hist <= 1'b0;
			sel_hist <= 1'b1;
		end else begin
			clk_hist <= pin_sync[4];
			sel_hist <= pin_sync[5];
		end
	end

	assign clk_rise = pin_sync[4] & ~clk_hist & ~pin_sync[5];
	assign sel_rise = pin_sync[5] & ~sel_hist;

	// lanes per clock follow the protocol
	always_comb begin
		case (proto_mode)
			FWE_PROTO_DUAL: begin
				next_shreg = {shreg[5:0], pin_sync[1:0]};
				next_cnt = bit_cnt + 6'h02;
			end
			FWE_PROTO_QUAD: begin
				next_shreg = {shreg[3:0], pin_sync[3:0]};
				next_cnt = bit_cnt + 6'h04;
			end
			default: begin
				next_shreg = {shreg[6:0], pin_sync[0]};
				next_cnt = bit_cnt + 6'h01;
			end
		endcase
		if (bit_cnt > BIT_COUNT_MAX - 6'h04) begin
			next_cnt = BIT_COUNT_MAX;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || pin_sync[5]) begin
			bit_cnt <= 6'h00;
			shreg <= 8'h00;
		end else if (clk_rise) begin
			bit_cnt <= next_cnt;
			shreg <= next_shreg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			opcode <= 8'h00;
			addr <= 24'h000000;
		end else if (clk_rise && next_cnt[2:0] == 3'h0 && bit_cnt < ADDR_CMD_BITS) begin
			if (next_cnt == OPCODE_BITS) begin
				opcode <= next_shreg;
			end else begin
				addr <= {addr[15:0], next_shreg};
			end
		end
	end

	// frame closes on the select rising edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			frame <= '0;
		end else begin
			frame.done <= sel_rise;
			frame.nbits <= bit_cnt;
			frame.opcode <= opcode;
			frame.addr <= addr;
		end
	end

endmodule
